// ===== core/e1_liu_loopback_control.sv
// Purpose: loop-back path steering between terminal data pins and line-side stages
// Assumes: line pins are digital pulse levels; tip high is a positive pulse, ring high a negative one
// Notes: transmit side runs on the falling edge of the bit clock; receive side runs on mclk
`timescale 1ns/1ps

// Notes on behaviour
// - local loop ignores the receive line pins entirely
// - local loop still drives terminal data out onto the transmit line
// - local loop feeds the transmit line signal through the receive path
// - local loop presents looped data on the receive data outputs
// - local loop selected while its active-low select input is held low
// - remote loop ignores the terminal transmit data inputs
// - remote loop still delivers received line data to the receive outputs
// - remote loop sends recovered receive data back out the transmit line
// - three loop modes, local, remote and digital, besides normal operation
// - transmit data pins sampled on the falling edge of the bit clock
// - positive data gives positive line pulse, negative data a negative pulse
// - positive received pulse drives positive output, negative drives negative output
module e1_liu_loopback_control
   import e1_loop_pkg::*;
(
   // clocks and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic tx_bit_clock_i,
   // loop selects, active low
   input wire logic local_loop_select_n_i,
   input wire logic remote_loop_select_n_i,
   input wire logic digital_loop_select_n_i,
   // terminal transmit data
   input wire logic tx_data_positive_i,
   input wire logic tx_data_negative_i,
   // receive line
   input wire logic rx_line_tip_i,
   input wire logic rx_line_ring_i,
   // transmit line
   output logic tx_line_tip_o,
   output logic tx_line_ring_o,
   // terminal receive data
   output logic rx_data_positive_o,
   output logic rx_data_negative_o,
   // active mode
   output logic [1:0] loop_mode_o
);

   function automatic loop_mode_e decode_mode(input logic l_n, input logic r_n, input logic d_n);
      loop_mode_e m;
      m = MODE_NORMAL;
      if (!l_n) begin
         m = MODE_LOCAL;
      end else if (!r_n) begin
         m = MODE_REMOTE;
      end else if (!d_n) begin
         m = MODE_DIGITAL;
      end
      return m;
   endfunction

   // mclk domain state
   loop_mode_e mode_q, mode_d;
   logic remote_q, remote_d;
   logic [1:0] tx_m_q, tx_m_d;
   logic tx_ack_q, tx_ack_d;
   logic [1:0] rx_q, rx_d;
   logic [1:0] rx_word_q, rx_word_d;
   logic rx_req_q, rx_req_d;
   logic [1:0] line_in;
   logic [SYNC_BUNDLE_W-1:0] sync_s;
   logic sel_local_n_s, sel_remote_n_s, sel_digital_n_s;
   logic [1:0] rx_pin_s;
   logic tx_req_s, rx_ack_s;

   // link domain state
   logic [1:0] lrst_q;
   logic link_rst;
   logic [2:0] lmeta_q, lstab_q;
   logic remote_l, rx_req_l, tx_ack_l;
   logic [1:0] tx_word_q, tx_word_d;
   logic [1:0] tx_line_q, tx_line_d;
   logic [1:0] tx_xfer_q, tx_xfer_d;
   logic tx_req_q, tx_req_d;
   logic [1:0] rx_loop_q, rx_loop_d;
   logic rx_ack_q, rx_ack_d;

   // pins and handshake bits from the link domain
   e1_sync_2ff #(.WIDTH(SYNC_BUNDLE_W)) u_sync (
      .clk_i(mclk_i),
      .reset_i(reset_i),
      .d_i({~local_loop_select_n_i, ~remote_loop_select_n_i, ~digital_loop_select_n_i,
            rx_line_tip_i, rx_line_ring_i, tx_req_q, rx_ack_q}),
      .q_o(sync_s)
   );

   // selects cross inverted, so a synchroniser cleared by reset reads as no request
   assign sel_local_n_s = ~sync_s[6];
   assign sel_remote_n_s = ~sync_s[5];
   assign sel_digital_n_s = ~sync_s[4];
   assign rx_pin_s = sync_s[3:2];
   assign tx_req_s = sync_s[1];
   assign rx_ack_s = sync_s[0];

   always_comb begin
      mode_d = decode_mode(sel_local_n_s, sel_remote_n_s, sel_digital_n_s);
      remote_d = (mode_q == MODE_REMOTE);
      // receive side of the transmit handshake
      tx_m_d = tx_m_q;
      tx_ack_d = tx_ack_q;
      if (tx_req_s != tx_ack_q) begin
         tx_m_d = tx_xfer_q;
         tx_ack_d = tx_req_s;
      end
      // local loop replaces the line input with the driven word
      line_in = (mode_q == MODE_LOCAL) ? tx_m_q : rx_pin_s;
      // digital loop bypasses the line stages
      rx_d = (mode_q == MODE_DIGITAL) ? tx_m_q : line_in;
      // offer received word to the transmit side
      rx_word_d = rx_word_q;
      rx_req_d = rx_req_q;
      if (rx_ack_s == rx_req_q) begin
         rx_word_d = line_in;
         rx_req_d = ~rx_req_q;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         mode_q <= MODE_RESET;
         remote_q <= 1'b0;
         tx_m_q <= RAIL_IDLE;
         tx_ack_q <= 1'b0;
         rx_q <= RAIL_IDLE;
         rx_word_q <= RAIL_IDLE;
         rx_req_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         remote_q <= remote_d;
         tx_m_q <= tx_m_d;
         tx_ack_q <= tx_ack_d;
         rx_q <= rx_d;
         rx_word_q <= rx_word_d;
         rx_req_q <= rx_req_d;
      end
   end

   // link reset: asserts at once, releases on link clock falling edges
   always_ff @(negedge tx_bit_clock_i or posedge reset_i) begin
      if (reset_i) begin
         lrst_q <= LINK_RST_ON;
      end else begin
         lrst_q <= {lrst_q[0], 1'b0};
      end
   end
   assign link_rst = lrst_q[1];

   // mclk-side levels into the link domain
   always_ff @(negedge tx_bit_clock_i or posedge link_rst) begin
      if (link_rst) begin
         lmeta_q <= 3'h0;
         lstab_q <= 3'h0;
      end else begin
         lmeta_q <= {remote_q, rx_req_q, tx_ack_q};
         lstab_q <= lmeta_q;
      end
   end
   assign remote_l = lstab_q[2];
   assign rx_req_l = lstab_q[1];
   assign tx_ack_l = lstab_q[0];

   always_comb begin
      tx_word_d = {tx_data_positive_i, tx_data_negative_i};
      // remote loop swaps the source; rails kept in order
      tx_line_d = remote_l ? rx_loop_q : tx_word_q;
      // a word is only handed over once the previous one was taken
      tx_xfer_d = tx_xfer_q;
      tx_req_d = tx_req_q;
      if (tx_ack_l == tx_req_q) begin
         tx_xfer_d = tx_line_q;
         tx_req_d = ~tx_req_q;
      end
      rx_loop_d = rx_loop_q;
      rx_ack_d = rx_ack_q;
      if (rx_req_l != rx_ack_q) begin
         rx_loop_d = rx_word_q;
         rx_ack_d = rx_req_l;
      end
   end

   always_ff @(negedge tx_bit_clock_i or posedge link_rst) begin
      if (link_rst) begin
         tx_word_q <= RAIL_IDLE;
         tx_line_q <= RAIL_IDLE;
         tx_xfer_q <= RAIL_IDLE;
         tx_req_q <= 1'b0;
         rx_loop_q <= RAIL_IDLE;
         rx_ack_q <= 1'b0;
      end else begin
         tx_word_q <= tx_word_d;
         tx_line_q <= tx_line_d;
         tx_xfer_q <= tx_xfer_d;
         tx_req_q <= tx_req_d;
         rx_loop_q <= rx_loop_d;
         rx_ack_q <= rx_ack_d;
      end
   end

   assign tx_line_tip_o = tx_line_q[RAIL_POS];
   assign tx_line_ring_o = tx_line_q[RAIL_NEG];
   assign rx_data_positive_o = rx_q[RAIL_POS];
   assign rx_data_negative_o = rx_q[RAIL_NEG];
   assign loop_mode_o = mode_q;

   a_local_ignores_rx: assert property (@(posedge mclk_i) disable iff (reset_i)
      (mode_q == MODE_LOCAL) |=> (rx_q == $past(tx_m_q)))
      else $error("local loop output not taken from the transmit word");

   a_local_rx_path: assert property (@(posedge mclk_i) disable iff (reset_i)
      (mode_q == MODE_LOCAL && mode_d == MODE_LOCAL && tx_req_s != tx_ack_q) |=> ##1 (rx_q == $past(tx_xfer_q, 2)))
      else $error("looped transmit word did not reach receive outputs");

   a_local_select: assert property (@(posedge mclk_i) disable iff (reset_i)
      (!sel_local_n_s) |=> (mode_q == MODE_LOCAL))
      else $error("local select low did not give local mode");

   a_select_priority: assert property (@(posedge mclk_i) disable iff (reset_i)
      (sel_local_n_s && !sel_remote_n_s) |=> (mode_q == MODE_REMOTE))
      else $error("remote select not honoured below local");

   a_digital_mode: assert property (@(posedge mclk_i) disable iff (reset_i)
      (sel_local_n_s && sel_remote_n_s && !sel_digital_n_s) |=> (mode_q == MODE_DIGITAL))
      else $error("digital select did not give digital mode");

   a_digital_return: assert property (@(posedge mclk_i) disable iff (reset_i)
      (mode_q == MODE_DIGITAL) |=> (rx_q == $past(tx_m_q)))
      else $error("digital loop output not from sampled transmit data");

   a_rx_rails: assert property (@(posedge mclk_i) disable iff (reset_i)
      (mode_q == MODE_NORMAL || mode_q == MODE_REMOTE) |=> (rx_q == $past(rx_pin_s)))
      else $error("receive rails not following the line pins");

   a_tx_normal: assert property (@(negedge tx_bit_clock_i) disable iff (link_rst)
      (!remote_l) |=> (tx_line_q == $past(tx_word_q)))
      else $error("transmit line not following sampled terminal data");

   a_remote_tx: assert property (@(negedge tx_bit_clock_i) disable iff (link_rst)
      (remote_l) |=> (tx_line_q == $past(rx_loop_q)))
      else $error("remote loop did not send received data to the line");

   a_tx_sample: assert property (@(negedge tx_bit_clock_i) disable iff (link_rst)
      ##1 1'b1 |-> (tx_word_q == $past({tx_data_positive_i, tx_data_negative_i})))
      else $error("transmit pins not captured on the falling edge");

   c_local: cover property (@(posedge mclk_i) disable iff (reset_i) mode_q == MODE_LOCAL ##4 rx_q != RAIL_IDLE);
   c_remote: cover property (@(negedge tx_bit_clock_i) disable iff (link_rst) remote_l ##1 tx_line_q != RAIL_IDLE);
   c_digital: cover property (@(posedge mclk_i) disable iff (reset_i) mode_q == MODE_DIGITAL ##2 rx_q != RAIL_IDLE);

endmodule // e1_liu_loopback_control

// ===== core/e1_loop_pkg.sv
// Purpose: shared constants and types for the e1 loop-back steering block
// Assumes: dual-rail words carry the positive rail in bit 1 and the negative rail in bit 0
// Notes: mode codes follow a gray walk normal-local-remote-digital
package e1_loop_pkg;

   typedef enum logic [1:0] {
      MODE_NORMAL  = 2'b00,
      MODE_LOCAL   = 2'b01,
      MODE_REMOTE  = 2'b11,
      MODE_DIGITAL = 2'b10
   } loop_mode_e;

   // dual-rail word layout
   localparam int unsigned RAIL_POS = 1;
   localparam int unsigned RAIL_NEG = 0;

   // values after reset
   localparam logic [1:0] RAIL_IDLE = 2'h0;
   localparam loop_mode_e MODE_RESET = MODE_NORMAL;
   localparam logic [1:0] LINK_RST_ON = 2'h3;

   // width of the mclk-side synchroniser bundle
   localparam int unsigned SYNC_BUNDLE_W = 7;

   // nominal transmit bit clock, for reference by users of the block
   localparam int unsigned TX_BIT_CLOCK_KHZ = 2048;

endpackage

// ===== core/e1_sync_2ff.sv
// Purpose: two flip-flop level synchroniser for a bundle of independent bits
// Assumes: every bit is a slow level or a 2-phase handshake bit
// Notes: first stage feeds the second stage only
`timescale 1ns/1ps
module e1_sync_2ff #(
   parameter int unsigned WIDTH = 1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] stable_q;
   logic [WIDTH-1:0] stable_d;

   // elaboration check: an empty bundle has nothing to carry
   if (WIDTH < 1) begin : g_width_check
      $error("e1_sync_2ff: WIDTH must be at least 1");
   end

   always_comb begin
      meta_d = d_i;
      stable_d = meta_q;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_q <= '0;
         stable_q <= '0;
      end else begin
         meta_q <= meta_d;
         stable_q <= stable_d;
      end
   end

   assign q_o = stable_q;

endmodule // e1_sync_2ff

// ===== test/e1_framer_model.sv
// Purpose: terminal-side framer model, makes the bit clock and the transmit rails
// Assumes: the transmit bit clock runs free, as a framer's does
// Notes: rails change on the rising edge, half a period clear of the sampling edge
`timescale 1ns/1ps
module e1_framer_model #(
   parameter real HALF_NS = 6.0
) (
   // word to send, positive rail in bit 1
   input wire logic [1:0] word_i,
   // terminal transmit pins
   output logic tx_bit_clock_o,
   output logic tx_data_positive_o,
   output logic tx_data_negative_o
);
   initial begin
      tx_bit_clock_o = 1'b0;
      tx_data_positive_o = 1'b0;
      tx_data_negative_o = 1'b0;
      // odd offset keeps the link clock unrelated in phase to mclk
      #3.7;
      forever #(HALF_NS) tx_bit_clock_o = ~tx_bit_clock_o;
   end
   always @(posedge tx_bit_clock_o) begin
      tx_data_positive_o <= word_i[1];
      tx_data_negative_o <= word_i[0];
   end
endmodule // e1_framer_model

// ===== test/e1_liu_loopback_control_tb.sv
// Purpose: self-checking bench for the loop-back steering block
// Assumes: data held long enough for the cross-domain handshakes to settle
// Notes: every select combination is walked, with random rail words in each
`timescale 1ns/1ps
module e1_liu_loopback_control_tb;
   import e1_loop_pkg::*;
   logic mclk_i, reset_i, tx_bit_clock, tx_pos, tx_neg, tx_tip, tx_ring, rx_pos, rx_neg;
   logic [2:0] sel_n;
   logic [1:0] tx_word, rx_word, loop_mode;
   logic [31:0] lfsr;
   logic hung;
   int num_errors = 0;
   int n_tests = 0;

   e1_framer_model u_e1_framer_model (.word_i(tx_word), .tx_bit_clock_o(tx_bit_clock),
      .tx_data_positive_o(tx_pos), .tx_data_negative_o(tx_neg));
   e1_liu_loopback_control u_e1_liu_loopback_control (.mclk_i(mclk_i), .reset_i(reset_i),
      .tx_bit_clock_i(tx_bit_clock), .local_loop_select_n_i(sel_n[2]),
      .remote_loop_select_n_i(sel_n[1]), .digital_loop_select_n_i(sel_n[0]),
      .tx_data_positive_i(tx_pos), .tx_data_negative_i(tx_neg),
      .rx_line_tip_i(rx_word[1]), .rx_line_ring_i(rx_word[0]),
      .tx_line_tip_o(tx_tip), .tx_line_ring_o(tx_ring),
      .rx_data_positive_o(rx_pos), .rx_data_negative_o(rx_neg), .loop_mode_o(loop_mode));

   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // both rails high is not a legal line symbol, so fold it to idle
   function automatic logic [1:0] rail_of(input logic [1:0] r);
      return (r == 2'h3) ? 2'h0 : r;
   endfunction

   function automatic loop_mode_e mode_of(input logic [2:0] s);
      if (!s[2]) return MODE_LOCAL;
      if (!s[1]) return MODE_REMOTE;
      if (!s[0]) return MODE_DIGITAL;
      return MODE_NORMAL;
   endfunction

   // remote sends the line word back out
   function automatic logic [1:0] tx_line_of(input loop_mode_e m, input logic [1:0] t, input logic [1:0] r);
      return (m == MODE_REMOTE) ? r : t;
   endfunction

   // local and digital return the terminal word
   function automatic logic [1:0] rx_data_of(input loop_mode_e m, input logic [1:0] t, input logic [1:0] r);
      return (m inside {MODE_LOCAL, MODE_DIGITAL}) ? t : r;
   endfunction

   task automatic end_sim;
      if (num_errors == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [1:0] got, input logic [1:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_mode(input logic [1:0] got, input loop_mode_e exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick;
      @(posedge mclk_i);
      #1;
   endtask

   task automatic run_combo(input logic [2:0] sel);
      loop_mode_e exp;
      int k;
      exp = mode_of(sel);
      @(posedge mclk_i);
      sel_n <= sel;
      k = 0;
      tick();
      while (loop_mode !== exp && k < 20) begin
         tick();
         k++;
      end
      chk_mode(loop_mode, exp);
      if (k == 20) begin
         hung = 1'b1;
         return;
      end
      repeat (3) begin
         lfsr = lfsr_next(lfsr);
         @(posedge mclk_i);
         tx_word <= rail_of(lfsr[3:2]);
         rx_word <= rail_of(lfsr[1:0]);
         repeat (16) tick();
         chk_val({tx_tip, tx_ring}, tx_line_of(exp, tx_word, rx_word));
         chk_val({rx_pos, rx_neg}, rx_data_of(exp, tx_word, rx_word));
      end
   endtask

   initial begin
      reset_i = 1'b1;
      sel_n = 3'h7;
      tx_word = 2'h0;
      rx_word = 2'h0;
      lfsr = 32'ha123;
      hung = 1'b0;
      repeat (5) tick();
      chk_mode(loop_mode, MODE_RESET);
      chk_val({rx_pos, rx_neg}, RAIL_IDLE);
      chk_val({tx_tip, tx_ring}, RAIL_IDLE);
      @(posedge mclk_i);
      reset_i <= 1'b0;
      // idle selects must not read as a request while the synchroniser fills
      repeat (2) begin
         tick();
         chk_mode(loop_mode, MODE_NORMAL);
      end
      // walk from no select down to all selects low, then back to normal
      for (int i = 7; i >= 0; i--) begin
         if (!hung) begin
            run_combo(i[2:0]);
         end
      end
      if (!hung) begin
         run_combo(3'h7);
      end
      end_sim();
   end
endmodule // e1_liu_loopback_control_tb
